// file: core/fpm_freq_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpm_map.svh"
module fpm_freq_ramp #(
  parameter logic [15:0] STEP = 16'h0001
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ms_tick,
  input wire logic ramp_en,
  input wire logic [15:0] target,
  output logic [15:0] cur_ff
);
  // Battery mode slews toward target; grid mode follows it directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff <= `FPM_FREQ_50;
    end else if (!ramp_en) begin
      cur_ff <= target;
    end else if (ms_tick && cur_ff < target) begin
      cur_ff <= (target - cur_ff > STEP) ? cur_ff + STEP : target;
    end else if (ms_tick && cur_ff > target) begin
      cur_ff <= (cur_ff - target > STEP) ? cur_ff - STEP : target;
    end
  end
endmodule
`default_nettype wire

// file: core/fpm_key_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fpm_key_if;
  import fpm_pkg::*;
  logic rel_valid;
  fpm_key_t rel_key;
  logic [15:0] rel_ms;
  logic long_enter;
  logic any_down;
  modport src (output rel_valid, output rel_key, output rel_ms, output long_enter,
               output any_down);
  modport dst (input rel_valid, input rel_key, input rel_ms, input long_enter,
               input any_down);
endinterface
`default_nettype wire

// file: core/fpm_key_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpm_map.svh"
module fpm_key_timer
  import fpm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ms_tick,
  input wire logic [3:0] keys,
  fpm_key_if.src ev
);
  logic held_ff;
  fpm_key_t key_ff;
  logic [15:0] cnt_ff;
  logic rel_ff;
  logic long_ff;

  // Only the first key pressed is timed; others are ignored until release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_ff <= 1'b0;
      key_ff <= KEY_UP;
    end else if (!held_ff && keys != 4'h0) begin
      held_ff <= 1'b1;
      key_ff <= keys[0] ? KEY_UP : keys[1] ? KEY_DOWN : keys[2] ? KEY_ENTER : KEY_ESC;
    end else if (held_ff && !keys[key_ff]) begin
      held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 16'h0000;
    end else if (!held_ff) begin
      cnt_ff <= 16'h0000;
    end else if (ms_tick && cnt_ff != 16'hffff) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rel_ff <= 1'b0;
      long_ff <= 1'b0;
    end else begin
      rel_ff <= held_ff && !keys[key_ff];
      long_ff <= held_ff && keys[key_ff] && key_ff == KEY_ENTER && ms_tick &&
                 cnt_ff == `FPM_LONG_MS;
    end
  end

  assign ev.rel_valid = rel_ff;
  assign ev.rel_key = key_ff;
  assign ev.rel_ms = cnt_ff;
  assign ev.long_enter = long_ff;
  assign ev.any_down = held_ff;
endmodule
`default_nettype wire

// file: core/fpm_map.svh
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FPM_CLK_MHZ 20
`define FPM_TICK_US 1000
`define FPM_TICK_CYC (`FPM_CLK_MHZ * `FPM_TICK_US)
`define FPM_PAGE_MIN_MS 16'd200
`define FPM_PAGE_MAX_MS 16'd1000
`define FPM_SHORT_MIN_MS 16'd100
`define FPM_SHORT_MAX_MS 16'd2000
`define FPM_LONG_MS 16'd2000
`define FPM_IDLE_MS 16'd30000

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define FPM_REG_CTRL 8'h00
`define FPM_REG_CMD 8'h04
`define FPM_REG_DISP 8'h08
`define FPM_REG_SET 8'h0c
`define FPM_REG_FREQ 8'h10

// ------------------------------------------------------------
// Fields and values
// ------------------------------------------------------------
`define FPM_CTRL_FAULT 0
`define FPM_CTRL_ALARM 1
`define FPM_CTRL_LINK_FAIL 2
`define FPM_CTRL_BAT_MODE 3
`define FPM_CTRL_PARALLEL 4
`define FPM_CTRL_PARALLEL_FLASH 5
`define FPM_CMD_RESTART 0
`define FPM_LAST_PAGE 5'd17
`define FPM_ALARM_PAGE 5'd18
`define FPM_FREQ_50 16'd5000
`define FPM_FREQ_60 16'd6000
`define FPM_RATED_FULL 8'd100
`define FPM_RATED_DERATED 8'd90
`define FPM_AXI_OKAY 2'b00
`define FPM_AXI_SLVERR 2'b10

`endif

// file: core/fpm_pkg.sv
package fpm_pkg;
  typedef enum logic [1:0] {KEY_UP, KEY_DOWN, KEY_ENTER, KEY_ESC} fpm_key_t;
  typedef enum logic [1:0] {VOLT_208, VOLT_220, VOLT_230, VOLT_240} fpm_volt_t;
  typedef enum logic [1:0] {ST_VIEW, ST_SELECT, ST_EDIT, ST_SET} fpm_state_t;
  typedef enum logic {ITEM_VOLT, ITEM_FREQ} fpm_item_t;
  typedef enum logic [3:0] {
    SHOW_MAIN_VF, SHOW_FAULT, SHOW_ALARM, SHOW_PAGE, SHOW_SINGLE, SHOW_PARALLEL,
    SHOW_PARALLEL_FLASH, SHOW_LINK_ERR, SHOW_CONST_VOLT
  } fpm_show_t;
endpackage

// file: core/fpm_top.sv
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_map.svh"
module fpm_top
  import fpm_pkg::*;
#(
  parameter int TICK_CYCLES = `FPM_TICK_CYC,
  parameter logic [15:0] RAMP_STEP = 16'h0001
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_enter,
  input wire logic key_esc,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic store_strobe,
  output logic [1:0] store_volt
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic in_window(input logic [15:0] ms, input logic [15:0] lo,
                                     input logic [15:0] hi);
    in_window = ms >= lo && ms <= hi;
  endfunction

  function automatic logic [15:0] freq_of(input logic sel);
    freq_of = sel ? `FPM_FREQ_60 : `FPM_FREQ_50;
  endfunction

  // ------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------
  logic [15:0] div_ff;
  logic tick_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (div_ff == 16'(TICK_CYCLES - 1)) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  fpm_key_if kev ();

  fpm_key_timer u_keys (
    .aclk(aclk),
    .aresetn(aresetn),
    .ms_tick(tick_ff),
    .keys({key_esc, key_enter, key_down, key_up}),
    .ev(kev.src)
  );

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [5:0] ctrl_ff;
  logic restart_ff;
  logic aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;

  assign do_write = aw_ff && w_ff && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_ff <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_ff <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPM_AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_ff == `FPM_REG_CTRL || awaddr_ff == `FPM_REG_CMD) ?
                     `FPM_AXI_OKAY : `FPM_AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= 6'h00;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= do_write && awaddr_ff == `FPM_REG_CMD && wstrb_ff[0] &&
                    wdata_ff[`FPM_CMD_RESTART];
      if (do_write && awaddr_ff == `FPM_REG_CTRL && wstrb_ff[0]) begin
        ctrl_ff <= wdata_ff[5:0];
      end
    end
  end

  logic fault, alarm, link_fail, bat_mode;
  assign fault = ctrl_ff[`FPM_CTRL_FAULT];
  assign alarm = ctrl_ff[`FPM_CTRL_ALARM];
  assign link_fail = ctrl_ff[`FPM_CTRL_LINK_FAIL];
  assign bat_mode = ctrl_ff[`FPM_CTRL_BAT_MODE];

  // ------------------------------------------------------------
  // Menu and pages
  // ------------------------------------------------------------
  fpm_state_t state_ff;
  fpm_item_t item_ff;
  logic [4:0] page_ff;
  logic [15:0] idle_ff;
  fpm_volt_t volt_ff;
  logic freq_sel_ff, freq_edit_ff, freq_pend_ff, freq_applied_ff;
  logic rel_short, rel_page, step_up, step_dn;
  logic [4:0] top_page;

  assign rel_short = kev.rel_valid && in_window(kev.rel_ms, `FPM_SHORT_MIN_MS,
                                                `FPM_SHORT_MAX_MS);
  assign rel_page = kev.rel_valid && in_window(kev.rel_ms, `FPM_PAGE_MIN_MS,
                                               `FPM_PAGE_MAX_MS);
  assign step_up = kev.rel_key == KEY_UP;
  assign step_dn = kev.rel_key == KEY_DOWN;
  assign top_page = alarm ? `FPM_ALARM_PAGE : `FPM_LAST_PAGE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_VIEW;
      item_ff <= ITEM_VOLT;
    end else if (state_ff == ST_VIEW) begin
      if (kev.long_enter) begin
        state_ff <= ST_SELECT;
        item_ff <= ITEM_VOLT;
      end
    end else if (tick_ff && idle_ff == `FPM_IDLE_MS - 16'd1) begin
      state_ff <= ST_VIEW;
    end else if (rel_short) begin
      unique case (kev.rel_key)
        KEY_UP, KEY_DOWN: begin
          if (state_ff != ST_EDIT) begin
            item_ff <= (item_ff == ITEM_VOLT) ? ITEM_FREQ : ITEM_VOLT;
            state_ff <= ST_SELECT;
          end
        end
        KEY_ENTER: state_ff <= (state_ff == ST_EDIT) ? ST_SET : ST_EDIT;
        KEY_ESC: state_ff <= ST_VIEW;
      endcase
    end
  end

  // Idle time counts only while no key is down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_ff <= 16'h0000;
    end else if (state_ff == ST_VIEW || kev.any_down) begin
      idle_ff <= 16'h0000;
    end else if (tick_ff && idle_ff != `FPM_IDLE_MS) begin
      idle_ff <= idle_ff + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_ff <= 5'd0;
    end else if (state_ff != ST_VIEW) begin
      page_ff <= 5'd0;
    end else if (page_ff > top_page) begin
      page_ff <= 5'd0;
    end else if (rel_page && step_dn) begin
      page_ff <= (page_ff == top_page) ? 5'd0 : page_ff + 5'd1;
    end else if (rel_page && step_up) begin
      page_ff <= (page_ff == 5'd0) ? top_page : page_ff - 5'd1;
    end
  end

  // ------------------------------------------------------------
  // Settings
  // ------------------------------------------------------------
  logic edit_volt, edit_freq;
  assign edit_volt = state_ff == ST_EDIT && item_ff == ITEM_VOLT && rel_short;
  assign edit_freq = state_ff == ST_EDIT && item_ff == ITEM_FREQ && rel_short;

  // Voltage applies and is stored on every step, not on exit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      volt_ff <= VOLT_230;
      store_strobe <= 1'b0;
      store_volt <= VOLT_230;
    end else begin
      store_strobe <= 1'b0;
      if (edit_volt && (step_up || step_dn)) begin
        volt_ff <= step_dn ? fpm_volt_t'(volt_ff + 2'd1) : fpm_volt_t'(volt_ff - 2'd1);
        store_strobe <= 1'b1;
        store_volt <= step_dn ? volt_ff + 2'd1 : volt_ff - 2'd1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_edit_ff <= 1'b0;
      freq_sel_ff <= 1'b0;
      freq_pend_ff <= 1'b0;
    end else begin
      if (state_ff == ST_SELECT) begin
        freq_edit_ff <= freq_sel_ff;
      end else if (edit_freq && (step_up || step_dn)) begin
        freq_edit_ff <= !freq_edit_ff;
      end
      if (edit_freq && (kev.rel_key == KEY_ENTER || kev.rel_key == KEY_ESC) &&
          freq_edit_ff != freq_sel_ff) begin
        freq_sel_ff <= freq_edit_ff;
        freq_pend_ff <= bat_mode;
      end else if (restart_ff || !bat_mode) begin
        freq_pend_ff <= 1'b0;
      end
    end
  end

  // Applied frequency follows the setting except while a battery-mode change waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_applied_ff <= 1'b0;
    end else if (!bat_mode || restart_ff || !freq_pend_ff) begin
      if (!(edit_freq && bat_mode)) begin
        freq_applied_ff <= freq_sel_ff;
      end
    end
  end

  logic [15:0] freq_now;

  fpm_freq_ramp #(
    .STEP(RAMP_STEP)
  ) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .ms_tick(tick_ff),
    .ramp_en(bat_mode),
    .target(freq_of(freq_applied_ff)),
    .cur_ff(freq_now)
  );

  // ------------------------------------------------------------
  // Display content
  // ------------------------------------------------------------
  fpm_show_t show;
  always_comb begin
    show = SHOW_PAGE;
    if (page_ff == 5'd0) begin
      show = fault ? SHOW_FAULT : alarm ? SHOW_ALARM : SHOW_MAIN_VF;
    end else if (page_ff == `FPM_ALARM_PAGE) begin
      show = SHOW_ALARM;
    end else if (page_ff == 5'd12) begin
      show = !ctrl_ff[`FPM_CTRL_PARALLEL] ? SHOW_SINGLE :
             ctrl_ff[`FPM_CTRL_PARALLEL_FLASH] ? SHOW_PARALLEL_FLASH : SHOW_PARALLEL;
    end else if (page_ff >= 5'd13 && link_fail) begin
      show = SHOW_LINK_ERR;
    end else if (page_ff == 5'd16) begin
      show = SHOW_CONST_VOLT;
    end
  end

  logic [31:0] disp_word, set_word;
  assign disp_word = {8'h00, show, 2'b00, state_ff == ST_EDIT, state_ff == ST_SELECT,
                      3'b000, item_ff, 2'b00, state_ff, 3'b000, page_ff};
  assign set_word = {16'h0000, (volt_ff == VOLT_208) ? `FPM_RATED_DERATED :
                     `FPM_RATED_FULL, 2'b00, freq_pend_ff, freq_sel_ff, 2'b00, volt_ff};

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FPM_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FPM_AXI_OKAY;
      unique case (s_axi_araddr)
        `FPM_REG_CTRL: s_axi_rdata <= {26'h0, ctrl_ff};
        `FPM_REG_CMD: s_axi_rdata <= 32'h0000_0000;
        `FPM_REG_DISP: s_axi_rdata <= disp_word;
        `FPM_REG_SET: s_axi_rdata <= set_word;
        `FPM_REG_FREQ: s_axi_rdata <= {freq_of(freq_applied_ff), freq_now};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `FPM_AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verification/fpm_operator.sv
`timescale 1ns/1ps
`default_nettype none
module fpm_operator #(
  parameter int TICK_CYCLES = 2
) (
  input wire logic aclk,
  output logic key_up,
  output logic key_down,
  output logic key_enter,
  output logic key_esc
);
  // One finger only: a key is let go before the next goes down
  logic [3:0] held;
  initial held = 4'h0;
  assign {key_esc, key_enter, key_down, key_up} = held;
  // Key k: 0 up, 1 down, 2 enter, 3 esc; gap after release lets the page settle
  task automatic press(input int k, input int ms);
    @(posedge aclk);
    held[k] <= 1'b1;
    repeat (ms * TICK_CYCLES) @(posedge aclk);
    held <= 4'h0;
    repeat (20) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// file: verification/fpm_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fpm_top_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic store_strobe,
  input wire logic [1:0] store_volt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles since UP or DOWN was last held; saturates so it stays small
  logic [3:0] idle_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || key_up || key_down) begin
      idle_ff <= 4'h0;
    end else if (idle_ff != 4'hf) begin
      idle_ff <= idle_ff + 4'h1;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_STORE_PULSE: assert property (store_strobe |=> !store_strobe)
    else $error("store strobe held past one cycle");
  AST_STORE_PROMPT: assert property (store_strobe |-> idle_ff inside {[4'h1:4'h8]})
    else $error("store strobe not right after a key release");
  AST_STORE_STEP: assert property (store_strobe |->
    (store_volt == $past(store_volt) + 2'd1) || (store_volt == $past(store_volt) - 2'd1))
    else $error("stored voltage code did not step by one");
  AST_STORE_DEFAULT: assert property ($rose(aresetn) |-> store_volt == 2'd2)
    else $error("stored voltage code not the default after reset");
  AST_B_AFTER_AW: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response not two cycles after address and data");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stayed after handshake");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready)
    else $error("read channel not freed after handshake");
  COV_STORE: cover property (store_strobe);
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind fpm_top fpm_top_assertions i_fpm_top_assertions (.aclk(aclk), .aresetn(aresetn),
  .key_up(key_up), .key_down(key_down), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .store_strobe(store_strobe), .store_volt(store_volt));
`default_nettype wire

// file: verification/fpm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpm_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %0h want %0h", $time, g, e); end end
module fpm_top_tb import fpm_pkg::*;;
  // Short tick keeps the 30 s idle wait inside the cycle budget
  localparam int TK = 2;
  logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, stb, ku, kd, ke, kx;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0] bresp, rresp, svolt, last_store, r;
  int n_fail, tests_run, cyc, n_store;
  fpm_top #(.TICK_CYCLES(TK)) i_fpm_top (.aclk(aclk), .aresetn(aresetn), .key_up(ku),
    .key_down(kd), .key_enter(ke), .key_esc(kx), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .store_strobe(stb), .store_volt(svolt));
  fpm_operator #(.TICK_CYCLES(TK)) i_fpm_operator (.aclk(aclk), .key_up(ku), .key_down(kd),
    .key_enter(ke), .key_esc(kx));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (stb === 1'b1) begin
      n_store++;
      last_store = svolt;
    end
    if (cyc == 100000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------
  // Bus and key helpers
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad, wdn;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    ad = 1'b0;
    wdn = 1'b0;
    do begin
      @(posedge aclk);
      ad |= awr;
      wdn |= wr;
      if (ad) awv <= 1'b0;
      if (wdn) wv <= 1'b0;
    end while (!(ad && wdn));
    while (bv !== 1'b1) @(posedge aclk);
    rs = bresp;
    br <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    v = rdat;
    rs = rresp;
    rr <= 1'b0;
  endtask
  task automatic key(input int k, input int ms);
    i_fpm_operator.press(k, ms);
  endtask
  task automatic ctrl(input logic [31:0] v);
    axi_wr(`FPM_REG_CTRL, v, r);
    `CHK(r, `FPM_AXI_OKAY)
  endtask
  task automatic dsp(input logic [4:0] pg, input logic [1:0] st, input logic [3:0] sh);
    axi_rd(`FPM_REG_DISP, d, r);
    `CHK(d[4:0], pg)
    `CHK(d[9:8], st)
    `CHK(d[23:20], sh)
  endtask
  // Blink is {value, name}
  task automatic menu(input logic [1:0] st, input logic it, input logic [1:0] blink);
    axi_rd(`FPM_REG_DISP, d, r);
    `CHK(d[9:8], st)
    `CHK(d[12], it)
    `CHK(d[17:16], blink)
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults;
    axi_rd(`FPM_REG_SET, d, r);
    `CHK(d[1:0], 2'd2)
    `CHK(d[4], 1'b0)
    `CHK(d[15:8], `FPM_RATED_FULL)
    axi_rd(`FPM_REG_FREQ, d, r);
    `CHK(d[31:16], `FPM_FREQ_50)
    axi_rd(8'h40, d, r);
    `CHK(r, `FPM_AXI_SLVERR)
    axi_wr(`FPM_REG_DISP, 32'h0, r);
    `CHK(r, `FPM_AXI_SLVERR)
    dsp(5'd0, ST_VIEW, SHOW_MAIN_VF);
  endtask
  task automatic t_pages;
    key(1, 300);
    dsp(5'd1, ST_VIEW, SHOW_PAGE);
    key(1, 150);
    dsp(5'd1, ST_VIEW, SHOW_PAGE);
    key(1, 1100);
    dsp(5'd1, ST_VIEW, SHOW_PAGE);
    key(0, 300);
    key(0, 300);
    dsp(5'd17, ST_VIEW, SHOW_PAGE);
    ctrl(32'h4);
    dsp(5'd17, ST_VIEW, SHOW_LINK_ERR);
    key(0, 300);
    dsp(5'd16, ST_VIEW, SHOW_LINK_ERR);
    ctrl(32'h0);
    dsp(5'd16, ST_VIEW, SHOW_CONST_VOLT);
    repeat (2) key(0, 300);
    dsp(5'd14, ST_VIEW, SHOW_PAGE);
    repeat (2) key(0, 300);
    dsp(5'd12, ST_VIEW, SHOW_SINGLE);
    ctrl(32'h10);
    dsp(5'd12, ST_VIEW, SHOW_PARALLEL);
    ctrl(32'h32);
    axi_rd(`FPM_REG_CTRL, d, r);
    `CHK(d, 32'h0000_0032)
    dsp(5'd12, ST_VIEW, SHOW_PARALLEL_FLASH);
    repeat (6) key(1, 300);
    dsp(5'd18, ST_VIEW, SHOW_ALARM);
    key(1, 300);
    dsp(5'd0, ST_VIEW, SHOW_ALARM);
    ctrl(32'h3);
    dsp(5'd0, ST_VIEW, SHOW_FAULT);
    ctrl(32'h0);
    dsp(5'd0, ST_VIEW, SHOW_MAIN_VF);
  endtask
  task automatic t_volt;
    key(2, 2100);
    menu(ST_SELECT, ITEM_VOLT, 2'b01);
    key(1, 150);
    menu(ST_SELECT, ITEM_FREQ, 2'b01);
    key(0, 150);
    key(2, 150);
    menu(ST_EDIT, ITEM_VOLT, 2'b10);
    n_store = 0;
    key(1, 150);
    `CHK(last_store, 2'd3)
    repeat (3) key(0, 150);
    axi_rd(`FPM_REG_SET, d, r);
    `CHK(d[1:0], 2'd0)
    `CHK(d[15:8], `FPM_RATED_DERATED)
    `CHK(n_store, 4)
    key(2, 150);
    menu(ST_SET, ITEM_VOLT, 2'b00);
    key(3, 150);
    dsp(5'd0, ST_VIEW, SHOW_MAIN_VF);
  endtask
  task automatic t_freq;
    key(2, 2100);
    key(1, 150);
    key(2, 150);
    key(1, 150);
    key(2, 150);
    axi_rd(`FPM_REG_FREQ, d, r);
    `CHK(d[31:16], `FPM_FREQ_60)
    `CHK(d[15:0], `FPM_FREQ_60)
    key(3, 150);
    ctrl(32'h8);
    key(2, 2100);
    key(1, 150);
    key(2, 150);
    key(1, 150);
    key(2, 150);
    axi_rd(`FPM_REG_SET, d, r);
    `CHK(d[5:4], 2'b10)
    repeat (29000 * TK) @(posedge aclk);
    menu(ST_SET, ITEM_FREQ, 2'b00);
    repeat (1100 * TK) @(posedge aclk);
    dsp(5'd0, ST_VIEW, SHOW_MAIN_VF);
    axi_wr(`FPM_REG_CMD, 32'h1, r);
    axi_rd(`FPM_REG_FREQ, d, r);
    `CHK(d[31:16], `FPM_FREQ_50)
    `CHK(d[15:0] > `FPM_FREQ_50, 1'b1)
    repeat (1100 * TK) @(posedge aclk);
    axi_rd(`FPM_REG_FREQ, d, r);
    `CHK(d[15:0], `FPM_FREQ_50)
  endtask
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {aresetn, awv, wv, br, arv, rr} = 6'h0;
    awa = 8'h0;
    ara = 8'h0;
    wd = 32'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_pages();
    t_volt();
    t_freq();
    wrap_up();
  end
endmodule
`default_nettype wire
